// >>> verilog/radio_fifo.sv
// transmit and receive byte fifos with thresholds and tx exit control
//
// Operation
// - two separate 64-byte fifos, transmit and receive
// - burst write to fifo address fills tx
// - burst read from fifo address drains rx
// - tx almost-full crossing raises an event
// - tx falling below almost-empty raises event
// - empty tx ends packet, leaves tx state
// - tx with oscillator bit returns to ready
// - tx with synthesizer bit returns to tune
// - tx-only start returns to ready, not standby
// - rx almost-full crossing raises an interrupt
// - control two bits 0,1 clear fifos
// - disabled source masks pin, status still set
// - packets start with alternating zero-one preamble
`timescale 1ns/1ps
module radio_fifo #(
    parameter int DEPTH = 64,
    parameter int PREAMBLE = radio_fifo_pkg::PRE_BITS
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire radio_fifo_pkg::reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic interrupt_request_pin_n_out,
    output radio_fifo_pkg::radio_state_t radio_state_out,
    input wire logic link_clk_in,
    input wire logic link_rx_valid_in,
    input wire logic [7:0] link_rx_byte_in,
    output logic link_tx_bit_out,
    output logic link_tx_active_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    // refuse sizes the pointer and threshold logic cannot serve, at elaboration
    if (DEPTH < 2 || DEPTH > 64 || DEPTH != (1 << AW)) begin
        $error("depth must be a power of two up to 64");
    end
    if (PREAMBLE < 2 || PREAMBLE > 255) begin
        $error("preamble length out of range");
    end

    // core-side state, all in one record
    typedef struct packed {
        logic [DEPTH-1:0][7:0] txm;
        logic [DEPTH-1:0][7:0] rxm;
        logic [AW-1:0] tx_wp;
        logic [AW-1:0] tx_rp;
        logic [CW-1:0] tx_cnt;
        logic [AW-1:0] rx_wp;
        logic [AW-1:0] rx_rp;
        logic [CW-1:0] rx_cnt;
        logic [7:0] ctrl2;
        logic [7:0] mode;
        logic [7:0] txaf;
        logic [7:0] txae;
        logic [7:0] rxaf;
        logic [7:0] status;
        logic [7:0] irq_en;
        logic [7:0] rdata;
        logic irq_n;
        radio_fifo_pkg::radio_state_t rstate;
        logic [7:0] tx_byte; // byte offered to the link
        logic tx_req; // toggles per offered byte
        logic ack_s1;
        logic ack_s2;
        logic busy_s1;
        logic busy_s2;
        logic seen_busy; // link has started this packet
        logic rxq_s1;
        logic rxq_s2;
        logic rx_ack;
    } core_t;

    // link-side state
    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic act_s1;
        logic act_s2;
        logic req_s1;
        logic req_s2;
        logic tx_ack;
        radio_fifo_pkg::link_state_t st;
        logic [7:0] sh; // bit shifter, msb first
        logic [3:0] bitc; // bits left in shifter
        logic [7:0] hold; // next byte, taken from the core early
        logic hold_full;
        logic [7:0] prec; // preamble bits left
        logic [7:0] rx_hold; // byte waiting for core
        logic rx_req;
        logic rxack_s1;
        logic rxack_s2;
        logic bit_out;
        logic active;
    } link_t;

    core_t cs;
    core_t next_cs;
    link_t ls;
    link_t next_ls;
    // per-cycle strobes
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic sent;
    logic [7:0] rest;

    // core next-state logic
    always_comb begin
        next_cs = cs;
        rest = cs.mode & ~(8'h01 << radio_fifo_pkg::MODE_TXON);
        // link-side flags through two flops each
        next_cs.ack_s1 = ls.tx_ack;
        next_cs.ack_s2 = cs.ack_s1;
        next_cs.busy_s1 = ls.active;
        next_cs.busy_s2 = cs.busy_s1;
        next_cs.rxq_s1 = ls.rx_req;
        next_cs.rxq_s2 = cs.rxq_s1;
        // full fifo silently drops host writes
        tx_push = reg_req_in.wr && reg_req_in.addr == radio_fifo_pkg::ADDR_FIFO
            && cs.tx_cnt != CW'(DEPTH);
        // offer next byte once the link took the last one
        tx_pop = cs.mode[radio_fifo_pkg::MODE_TXON] && cs.tx_req == cs.ack_s2
            && cs.tx_cnt != '0;
        rx_push = cs.rxq_s2 != cs.rx_ack;
        rx_pop = reg_req_in.rd && reg_req_in.addr == radio_fifo_pkg::ADDR_FIFO
            && cs.rx_cnt != '0;
        sent = cs.mode[radio_fifo_pkg::MODE_TXON] && cs.seen_busy && !cs.busy_s2
            && cs.tx_cnt == '0 && cs.tx_req == cs.ack_s2;
        // tx fifo
        if (tx_push) begin
            next_cs.txm[cs.tx_wp] = reg_req_in.wdata;
            next_cs.tx_wp = cs.tx_wp + AW'(1);
        end
        if (tx_pop) begin
            next_cs.tx_byte = cs.txm[cs.tx_rp];
            next_cs.tx_req = ~cs.tx_req;
            next_cs.tx_rp = cs.tx_rp + AW'(1);
        end
        next_cs.tx_cnt = cs.tx_cnt + CW'(tx_push) - CW'(tx_pop);
        // rx fifo, link byte always acked; a full fifo drops it
        if (rx_push) begin
            next_cs.rx_ack = cs.rxq_s2;
            if (cs.rx_cnt != CW'(DEPTH)) begin
                next_cs.rxm[cs.rx_wp] = ls.rx_hold;
                next_cs.rx_wp = cs.rx_wp + AW'(1);
            end
        end
        if (rx_pop) begin
            next_cs.rx_rp = cs.rx_rp + AW'(1);
        end
        next_cs.rx_cnt = cs.rx_cnt + CW'(rx_push && cs.rx_cnt != CW'(DEPTH)) - CW'(rx_pop);
        // register writes; reserved threshold bits read zero
        if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                radio_fifo_pkg::ADDR_MODE: next_cs.mode = reg_req_in.wdata;
                radio_fifo_pkg::ADDR_CTRL2: next_cs.ctrl2 = reg_req_in.wdata;
                radio_fifo_pkg::ADDR_IRQ_EN: next_cs.irq_en = reg_req_in.wdata;
                radio_fifo_pkg::ADDR_TXAF: next_cs.txaf = reg_req_in.wdata & radio_fifo_pkg::THR_MASK;
                radio_fifo_pkg::ADDR_TXAE: next_cs.txae = reg_req_in.wdata & radio_fifo_pkg::THR_MASK;
                radio_fifo_pkg::ADDR_RXAF: next_cs.rxaf = reg_req_in.wdata & radio_fifo_pkg::THR_MASK;
                default: next_cs.mode = next_cs.mode;
            endcase
        end
        // register reads, unmapped reads answer zero
        if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                radio_fifo_pkg::ADDR_STATUS: next_cs.rdata = cs.status;
                radio_fifo_pkg::ADDR_IRQ_EN: next_cs.rdata = cs.irq_en;
                radio_fifo_pkg::ADDR_MODE: next_cs.rdata = cs.mode;
                radio_fifo_pkg::ADDR_CTRL2: next_cs.rdata = cs.ctrl2;
                radio_fifo_pkg::ADDR_TXAF: next_cs.rdata = cs.txaf;
                radio_fifo_pkg::ADDR_TXAE: next_cs.rdata = cs.txae;
                radio_fifo_pkg::ADDR_RXAF: next_cs.rdata = cs.rxaf;
                radio_fifo_pkg::ADDR_FIFO: next_cs.rdata = rx_pop ? cs.rxm[cs.rx_rp] : 8'h00;
                default: next_cs.rdata = 8'h00;
            endcase
            // reading status clears it
            if (reg_req_in.addr == radio_fifo_pkg::ADDR_STATUS) begin
                next_cs.status = 8'h00;
            end
        end
        // events land after the clear so a same-cycle set survives
        if (tx_push && !tx_pop && cs.tx_cnt == CW'(cs.txaf[5:0])) begin
            next_cs.status[radio_fifo_pkg::ST_TXAF] = 1'b1;
        end
        if (tx_pop && !tx_push && cs.tx_cnt == CW'(cs.txae[5:0])) begin
            next_cs.status[radio_fifo_pkg::ST_TXAE] = 1'b1;
        end
        if (rx_push && !rx_pop && cs.rx_cnt == CW'(cs.rxaf[5:0])) begin
            next_cs.status[radio_fifo_pkg::ST_RXAF] = 1'b1;
        end
        // packet start / end tracking
        if (cs.busy_s2) begin
            next_cs.seen_busy = 1'b1;
        end
        if (sent) begin
            next_cs.seen_busy = 1'b0;
            next_cs.status[radio_fifo_pkg::ST_PKSENT] = 1'b1;
            // drop txon, keep the rest; nothing left means ready
            next_cs.mode = rest;
            if (rest == 8'h00) begin
                next_cs.mode[radio_fifo_pkg::MODE_XTON] = 1'b1;
            end
        end
        // clear bits win over any traffic on their fifo
        if (cs.ctrl2[radio_fifo_pkg::CLR_TX]) begin
            next_cs.tx_wp = '0;
            next_cs.tx_rp = '0;
            next_cs.tx_cnt = '0;
        end
        if (cs.ctrl2[radio_fifo_pkg::CLR_RX]) begin
            next_cs.rx_wp = '0;
            next_cs.rx_rp = '0;
            next_cs.rx_cnt = '0;
        end
        // masked sources never reach the pin
        next_cs.irq_n = ~|(next_cs.status & next_cs.irq_en);
        // state seen from the mode bits, tx first
        if (next_cs.mode[radio_fifo_pkg::MODE_TXON]) begin
            next_cs.rstate = radio_fifo_pkg::RS_TX;
        end else if (next_cs.mode[radio_fifo_pkg::MODE_RXON]) begin
            next_cs.rstate = radio_fifo_pkg::RS_RX;
        end else if (next_cs.mode[radio_fifo_pkg::MODE_PLLON]) begin
            next_cs.rstate = radio_fifo_pkg::RS_TUNE;
        end else if (next_cs.mode[radio_fifo_pkg::MODE_XTON]) begin
            next_cs.rstate = radio_fifo_pkg::RS_READY;
        end else begin
            next_cs.rstate = radio_fifo_pkg::RS_STANDBY;
        end
    end

    localparam logic [7:0] RST_TXAF_C = radio_fifo_pkg::RST_TXAF;
    localparam logic [7:0] RST_TXAE_C = radio_fifo_pkg::RST_TXAE;
    localparam logic [7:0] RST_RXAF_C = radio_fifo_pkg::RST_RXAF;

    // core registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cs <= '0;
            cs.txaf <= RST_TXAF_C;
            cs.txae <= RST_TXAE_C;
            cs.rxaf <= RST_RXAF_C;
            cs.irq_n <= 1'b1;
        end else if (clk_en_in) begin
            cs <= next_cs;
        end
    end

    // link next-state logic; the enable crosses like any level
    always_comb begin
        next_ls = ls;
        next_ls.en_s1 = clk_en_in;
        next_ls.en_s2 = ls.en_s1;
        if (ls.en_s2) begin
            next_ls.act_s1 = cs.mode[radio_fifo_pkg::MODE_TXON];
            next_ls.act_s2 = ls.act_s1;
            next_ls.req_s1 = cs.tx_req;
            next_ls.req_s2 = ls.req_s1;
            next_ls.rxack_s1 = cs.rx_ack;
            next_ls.rxack_s2 = ls.rxack_s1;
            // one byte in flight; a byte arriving while busy is lost
            if (link_rx_valid_in && ls.rx_req == ls.rxack_s2) begin
                next_ls.rx_hold = link_rx_byte_in;
                next_ls.rx_req = ~ls.rx_req;
            end
            // take the next byte while the shifter works; one byte per toggle round trip,
            // so a link clock far faster than the core can still run dry on long packets
            if (!ls.hold_full && ls.req_s2 != ls.tx_ack) begin
                next_ls.hold = cs.tx_byte; // core holds tx_byte steady until acked
                next_ls.hold_full = 1'b1;
                next_ls.tx_ack = ls.req_s2;
            end
            case (ls.st)
                radio_fifo_pkg::LK_IDLE: begin
                    if (ls.act_s2) begin
                        next_ls.st = radio_fifo_pkg::LK_PRE;
                        next_ls.prec = 8'(PREAMBLE - 1);
                        next_ls.bit_out = 1'b0;
                        next_ls.active = 1'b1;
                    end
                end
                radio_fifo_pkg::LK_PRE: begin
                    next_ls.prec = ls.prec - 8'h01;
                    next_ls.bit_out = ~ls.bit_out;
                end
                radio_fifo_pkg::LK_DATA: begin
                    next_ls.bit_out = ls.sh[7];
                    next_ls.sh = {ls.sh[6:0], 1'b0};
                    next_ls.bitc = ls.bitc - 4'h1;
                end
                radio_fifo_pkg::LK_DONE: begin
                    // wait for txon to drop so the packet does not restart
                    if (!ls.act_s2) begin
                        next_ls.st = radio_fifo_pkg::LK_IDLE;
                    end
                end
                default: next_ls.st = radio_fifo_pkg::LK_IDLE;
            endcase
            // a byte is due right after the last preamble or data bit, no idle bit between
            if ((ls.st == radio_fifo_pkg::LK_PRE && ls.prec == 8'h00)
                || (ls.st == radio_fifo_pkg::LK_DATA && ls.bitc == 4'h0)) begin
                if (ls.hold_full) begin
                    next_ls.st = radio_fifo_pkg::LK_DATA;
                    next_ls.bit_out = ls.hold[7];
                    next_ls.sh = {ls.hold[6:0], 1'b0};
                    next_ls.bitc = 4'h7;
                    next_ls.hold_full = 1'b0;
                end else begin
                    // nothing more offered: the packet ends
                    next_ls.st = radio_fifo_pkg::LK_DONE;
                    next_ls.active = 1'b0;
                    next_ls.bit_out = 1'b0;
                end
            end
        end
    end

    // link registers
    always_ff @(posedge link_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ls <= '0;
        end else begin
            ls <= next_ls;
        end
    end

    // outputs straight from flops
    assign reg_rdata_out = cs.rdata;
    assign interrupt_request_pin_n_out = cs.irq_n;
    assign radio_state_out = cs.rstate;
    assign link_tx_bit_out = ls.bit_out;
    assign link_tx_active_out = ls.active;

    // checks
    fifo_bound_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cs.tx_cnt <= CW'(DEPTH) && cs.rx_cnt <= CW'(DEPTH))
        else $error("fifo count past depth");
    tx_fill_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && tx_push && !tx_pop && !cs.ctrl2[radio_fifo_pkg::CLR_TX]
        |=> cs.tx_cnt == $past(cs.tx_cnt) + CW'(1))
        else $error("tx write not counted");
    rx_drain_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && rx_pop |=> reg_rdata_out == $past(cs.rxm[cs.rx_rp]))
        else $error("rx read returned wrong byte");
    tx_full_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && tx_push && !tx_pop && cs.tx_cnt == CW'(cs.txaf[5:0])
        |=> cs.status[radio_fifo_pkg::ST_TXAF])
        else $error("tx almost full missed");
    tx_empty_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && tx_pop && !tx_push && cs.tx_cnt == CW'(cs.txae[5:0])
        |=> cs.status[radio_fifo_pkg::ST_TXAE])
        else $error("tx almost empty missed");
    rx_full_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && rx_push && !rx_pop && cs.rx_cnt == CW'(cs.rxaf[5:0])
        && !cs.ctrl2[radio_fifo_pkg::CLR_RX] |=> ##[0:2] !interrupt_request_pin_n_out
        || !cs.irq_en[radio_fifo_pkg::ST_RXAF])
        else $error("rx almost full did not reach pin");
    tune_return_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && sent && cs.mode == radio_fifo_pkg::MODE_TX_TUNE && !reg_req_in.wr
        |=> radio_state_out == radio_fifo_pkg::RS_TUNE)
        else $error("tx did not return to tune");
    ready_return_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && sent && cs.mode == radio_fifo_pkg::MODE_TX_ONLY && !reg_req_in.wr
        |=> radio_state_out == radio_fifo_pkg::RS_READY)
        else $error("tx-only start fell to standby");
    clear_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && cs.ctrl2[radio_fifo_pkg::CLR_TX] |=> cs.tx_cnt == '0 && cs.tx_wp == '0)
        else $error("tx clear did not empty fifo");
    mask_pin_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cs.irq_en == 8'h00 |-> interrupt_request_pin_n_out)
        else $error("masked source drove pin");
    preamble_alt_a: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        ls.st == radio_fifo_pkg::LK_PRE && $past(ls.st) == radio_fifo_pkg::LK_PRE
        && $past(ls.prec) != 8'h00 && $past(ls.en_s2) |-> ls.bit_out != $past(ls.bit_out))
        else $error("preamble not alternating");
endmodule

// >>> verilog/radio_fifo_pkg.sv
// shared constants and types for the radio byte fifo block
package radio_fifo_pkg;
    // register offsets
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam logic [6:0] ADDR_IRQ_EN = 7'h05;
    localparam logic [6:0] ADDR_MODE = 7'h07;
    localparam logic [6:0] ADDR_CTRL2 = 7'h08;
    localparam logic [6:0] ADDR_TXAF = 7'h7c;
    localparam logic [6:0] ADDR_TXAE = 7'h7d;
    localparam logic [6:0] ADDR_RXAF = 7'h7e;
    localparam logic [6:0] ADDR_FIFO = 7'h7f;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_TXAF = 8'h37;
    localparam logic [7:0] RST_TXAE = 8'h04;
    localparam logic [7:0] RST_RXAF = 8'h37;
    // threshold field is six bits, upper two reserved
    localparam logic [7:0] THR_MASK = 8'h3f;
    // operating mode bits
    localparam int MODE_XTON = 0;
    localparam int MODE_PLLON = 1;
    localparam int MODE_RXON = 2;
    localparam int MODE_TXON = 3;
    localparam logic [7:0] MODE_TX_ONLY = 8'h08;
    localparam logic [7:0] MODE_TX_TUNE = 8'h0a;
    // fifo clear bits
    localparam int CLR_TX = 0;
    localparam int CLR_RX = 1;
    // status / enable bits
    localparam int ST_PKSENT = 2;
    localparam int ST_RXAF = 4;
    localparam int ST_TXAE = 5;
    localparam int ST_TXAF = 6;
    // preamble length in bits
    localparam int PRE_BITS = 32;
    // radio state, gray along standby-ready-tune-tx
    typedef enum logic [2:0] {
        RS_STANDBY = 3'b000,
        RS_READY = 3'b001,
        RS_TUNE = 3'b011,
        RS_TX = 3'b010,
        RS_RX = 3'b110
    } radio_state_t;
    // link transmitter state
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_PRE = 2'b01,
        LK_DATA = 2'b11,
        LK_DONE = 2'b10
    } link_state_t;
    // one decoded register access from the serial port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// >>> testbench/radio_host_model.sv
// host side model that issues register accesses to the radio fifo block
`timescale 1ns/1ps
module radio_host_model (
    input wire logic clk_in,
    output radio_fifo_pkg::reg_req_t reg_req_out
);
    // bus idle at time zero so nothing is taken during reset
    initial begin
        reg_req_out = '0;
    end

    // one access per edge; the next call replaces it right after the taking edge
    task automatic access(input logic wr, input logic rd, input logic [6:0] addr, input logic [7:0] data);
        @(posedge clk_in);
        #1;
        reg_req_out = '{wr: wr, rd: rd, addr: addr, wdata: data};
    endtask

    // release after the taking edge; stale fields inverted so they never look held
    task automatic idle();
        @(posedge clk_in);
        #1;
        reg_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~reg_req_out.addr, wdata: ~reg_req_out.wdata};
    endtask
endmodule

// >>> testbench/test_radio_fifo.sv
// self-checking bench for the radio byte fifo block
`timescale 1ns/1ps
module test_radio_fifo;
    localparam int PRE = 16; // short, yet long enough for the first byte to reach the link
    logic clk_in = 1'b0; // core clock
    logic link_clk = 1'b0; // modem clock
    logic reset_n = 1'b0;
    logic clk_en = 1'b1; // core never frozen here
    logic rx_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    radio_fifo_pkg::reg_req_t reg_req;
    logic [7:0] rdata;
    logic pin_n;
    radio_fifo_pkg::radio_state_t state;
    logic tx_bit;
    logic tx_active;
    logic [7:0] rd_q[$]; // expected read data, oldest first
    logic bit_q[$]; // expected serial bits, oldest first
    logic rd_wait = 1'b0; // a read was taken at the last edge
    logic [31:0] seed = 32'h88e53c79;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] rxd [65]; // bytes sent over the link
    logic [6:0] raddr [8] = '{7'h03, 7'h05, 7'h07, 7'h08, 7'h7c, 7'h7d, 7'h7e, 7'h06};
    logic [7:0] rval [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h37, 8'h04, 8'h37, 8'h00};
    logic [7:0] modes [3] = '{8'h08, 8'h0a, 8'h09};
    logic [7:0] after [3] = '{8'h01, 8'h02, 8'h01};
    radio_fifo_pkg::radio_state_t ends [3] = '{radio_fifo_pkg::RS_READY, radio_fifo_pkg::RS_TUNE,
        radio_fifo_pkg::RS_READY};

    // core clock, 40 ns
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    // link clock, 15 ns, phase offset from the core clock
    initial begin
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end

    radio_fifo #(.DEPTH(64), .PREAMBLE(PRE)) u_radio_fifo (
        .clk_in(clk_in),
        .reset_n_in(reset_n),
        .clk_en_in(clk_en),
        .reg_req_in(reg_req),
        .reg_rdata_out(rdata),
        .interrupt_request_pin_n_out(pin_n),
        .radio_state_out(state),
        .link_clk_in(link_clk),
        .link_rx_valid_in(rx_valid),
        .link_rx_byte_in(rx_byte),
        .link_tx_bit_out(tx_bit),
        .link_tx_active_out(tx_active)
    );

    radio_host_model u_radio_host_model (
        .clk_in(clk_in),
        .reg_req_out(reg_req)
    );

    // fixed-seed xorshift source
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // one comparison, reported at once on mismatch
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic close_out();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // single register write
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_radio_host_model.access(1'b1, 1'b0, a, d);
        u_radio_host_model.idle();
    endtask

    // read inside a burst; expectation queued before the access
    task automatic frd(input logic [6:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        u_radio_host_model.access(1'b0, 1'b1, a, 8'h00);
    endtask

    // single register read
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        frd(a, e);
        u_radio_host_model.idle();
    endtask

    // burst of random bytes into tx, expected wire bits queued with preamble first
    task automatic load(input int n);
        logic [7:0] d;
        for (int k = 0; k < PRE; k++) bit_q.push_back(k[0]);
        for (int j = 0; j < n; j++) begin
            d = xs();
            for (int k = 7; k >= 0; k--) bit_q.push_back(d[k]);
            u_radio_host_model.access(1'b1, 1'b0, radio_fifo_pkg::ADDR_FIFO, d);
        end
        u_radio_host_model.idle();
    endtask

    // pin level a few cycles after its cause
    task automatic pin_is(input logic e);
        repeat (3) @(posedge clk_in);
        #1;
        check({7'h00, pin_n}, {7'h00, e});
    endtask

    // bounded wait for a radio state
    task automatic wait_state(input radio_fifo_pkg::radio_state_t s);
        int n;
        n = 0;
        while (state !== s && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        check({5'h00, state}, {5'h00, s});
    endtask

    // one received byte; line inverted after the pulse, spacing covers the handshake
    task automatic send_rx(input logic [7:0] b);
        @(posedge link_clk);
        #1;
        rx_valid = 1'b1;
        rx_byte = b;
        @(posedge link_clk);
        #1;
        rx_valid = 1'b0;
        rx_byte = ~b;
        repeat (12) @(posedge link_clk);
    endtask

    // read data is valid the cycle after the read is taken
    always @(posedge clk_in) begin
        if (rd_wait) begin
            check(rdata, rd_q.pop_front());
        end
        rd_wait = reg_req.rd;
    end

    // serial output checked bit by bit while a packet is on the wire
    always @(posedge link_clk) begin
        if (tx_active) begin
            if (bit_q.size() == 0) begin
                check(8'h01, 8'h00);
            end else begin
                check({7'h00, tx_bit}, {7'h00, bit_q.pop_front()});
            end
        end
    end

    // hang guard well above the expected run length
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("[ERR] %0t: run did not finish", $time);
            close_out();
        end
    end

    initial begin
        repeat (6) @(posedge clk_in);
        #1;
        reset_n = 1'b1;
        // reset values, unmapped address, reserved threshold bits
        for (int i = 0; i < 8; i++) rd(raddr[i], rval[i]);
        wr(radio_fifo_pkg::ADDR_TXAF, 8'hff);
        rd(radio_fifo_pkg::ADDR_TXAF, 8'h3f);
        $display("register test done");
        // tx almost-full at 2 -> 3 bytes, almost-empty at 2 -> 1 while sending
        wr(radio_fifo_pkg::ADDR_TXAF, 8'h02);
        wr(radio_fifo_pkg::ADDR_TXAE, 8'h02);
        wr(radio_fifo_pkg::ADDR_IRQ_EN, 8'h40);
        load(3);
        pin_is(1'b0);
        rd(radio_fifo_pkg::ADDR_STATUS, 8'h40);
        pin_is(1'b1);
        // exit modes; second pass clears a junk byte first
        for (int i = 0; i < 3; i++) begin
            if (i == 1) begin
                wr(radio_fifo_pkg::ADDR_FIFO, 8'h5a);
                wr(radio_fifo_pkg::ADDR_CTRL2, 8'h01);
                wr(radio_fifo_pkg::ADDR_CTRL2, 8'h00);
            end
            if (i > 0) begin
                load(1);
            end
            wr(radio_fifo_pkg::ADDR_MODE, modes[i]);
            repeat (3) @(posedge clk_in);
            wait_state(ends[i]);
            repeat (4) @(posedge clk_in);
            check({7'h00, pin_n}, 8'h01);
            rd(radio_fifo_pkg::ADDR_MODE, after[i]);
            rd(radio_fifo_pkg::ADDR_STATUS, (i == 0) ? 8'h24 : 8'h04);
            check({7'h00, bit_q.size() == 0}, 8'h01);
            wr(radio_fifo_pkg::ADDR_MODE, 8'h00);
            wait_state(radio_fifo_pkg::RS_STANDBY);
        end
        $display("tx test done");
        // rx fill past depth with the pin masked
        wr(radio_fifo_pkg::ADDR_RXAF, 8'h02);
        wr(radio_fifo_pkg::ADDR_IRQ_EN, 8'h00);
        for (int i = 0; i < 65; i++) begin
            rxd[i] = xs();
            send_rx(rxd[i]);
        end
        pin_is(1'b1);
        rd(radio_fifo_pkg::ADDR_STATUS, 8'h10);
        for (int i = 0; i < 65; i++) frd(radio_fifo_pkg::ADDR_FIFO, (i < 64) ? rxd[i] : 8'h00);
        u_radio_host_model.idle();
        // rx crossing with the pin enabled, once per crossing
        wr(radio_fifo_pkg::ADDR_IRQ_EN, 8'h10);
        for (int i = 0; i < 3; i++) send_rx(xs());
        pin_is(1'b0);
        rd(radio_fifo_pkg::ADDR_STATUS, 8'h10);
        pin_is(1'b1);
        send_rx(xs());
        pin_is(1'b1);
        rd(radio_fifo_pkg::ADDR_STATUS, 8'h00);
        // rx clear holds fifo empty
        wr(radio_fifo_pkg::ADDR_CTRL2, 8'h02);
        rd(radio_fifo_pkg::ADDR_FIFO, 8'h00);
        wr(radio_fifo_pkg::ADDR_CTRL2, 8'h00);
        rd(radio_fifo_pkg::ADDR_FIFO, 8'h00);
        $display("rx test done");
        repeat (2) @(posedge clk_in);
        close_out();
    end
endmodule
